//--- src/pdr_pkg.sv
`default_nettype none
package pdr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int CORE_W = 64;
    localparam int PRE_W = 3;
    localparam int MAIN_W = 4;
    localparam int POST_W = 3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FIR = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_THERM = 8'h0C;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RXAUI = 2;
    localparam int CTRL_LANE3 = 3;
    localparam int CTRL_ING_TS = 4;
    localparam int CTRL_EGR_TS = 5;
    localparam int CTRL_LOOP = 6;
    localparam int CTRL_MON = 7;
    localparam int CTRL_UNITY = 8;
    localparam int FIR_PRE_LSB = 0;
    localparam int FIR_MAIN_LSB = 4;
    localparam int FIR_POST_LSB = 8;
    localparam int STAT_WAN = 0;
    localparam int STAT_MON = 1;
    localparam int STAT_SYNC = 2;
    localparam int STAT_HALF = 3;
    localparam int THERM_MAIN_LSB = 8;
    localparam int THERM_POST_LSB = 24;

    // ------------------------------------------------------------
    // Reset values and lane masks
    // ------------------------------------------------------------
    localparam logic [PRE_W-1:0] FIR_PRE_RST = 3'h0;
    localparam logic [MAIN_W-1:0] FIR_MAIN_RST = 4'hF;
    localparam logic [POST_W-1:0] FIR_POST_RST = 3'h0;
    localparam logic [3:0] LANES_XAUI = 4'hF;
    localparam logic [3:0] LANES_RXAUI = 4'h5;
    localparam logic [3:0] LANE_ZERO = 4'h1;
    localparam logic [3:0] LANE_THREE = 4'h8;
    localparam logic [1:0] MODE_BAD = 2'h3;

    typedef enum logic [1:0] {
        MODE_LAN = 2'b00,
        MODE_WAN = 2'b01,
        MODE_1G = 2'b10
    } pdr_mode_t;

    typedef enum logic {
        DMX_LOW = 1'b0,
        DMX_HIGH = 1'b1
    } pdr_demux_t;

    typedef struct packed {
        pdr_mode_t mode;
        logic rxaui;
        logic lane3;
        logic ingTs;
        logic egrTs;
        logic loopback;
        logic monReq;
        logic unity;
        logic [PRE_W-1:0] firPre;
        logic [MAIN_W-1:0] firMain;
        logic [POST_W-1:0] firPost;
        pdr_demux_t dmx;
        logic [WORD_W-1:0] lowWord;
        logic [CORE_W-1:0] coreRxData;
        logic wanRxValid;
        logic pcs10RxValid;
        logic pcs1RxValid;
        logic laneSync;
        logic [CORE_W-1:0] hostTxData;
        logic hostTxValid;
        logic [WORD_W-1:0] lineTxWord;
        logic lineTxValid;
        logic rdy;
        logic [31:0] prdata;
        logic pslverr;
    } pdr_state_t;

endpackage : pdr_pkg
`default_nettype wire

//--- src/pdr_mode_router.sv
// How it works
// R01 - Line sender supplies LAN 66B words, WAN frames or 1G 8B/10B data.
// R02 - WAN mode hands recovered core words to the WAN framer.
// R03 - LAN mode feeds the 10G PCS; 1G mode feeds the line 1G PCS.
// R04 - 1G ingress may pass through timestamp and MAC chain by control bit.
// R05 - 10G ingress enables XGXS encoding on four XAUI or two RXAUI lanes.
// R06 - RXAUI transmit uses physical lanes 0 and 2 only.
// R07 - RXAUI host sends egress on lanes 0 and 2; device listens there.
// R08 - 1G ingress uses host 1G PCS, on lane 0 or lane 3.
// R09 - Host sends 1G data on the same lane the device transmits on.
// R10 - One 1G lane choice steers both host receive and transmit.
// R11 - 10G egress: per-lane clocks, XGXS decode, optional timestamp/MAC.
// R12 - LAN egress takes 10G PCS words to the line serializer.
// R13 - WAN egress takes framer words to the line serializer.
// R14 - 1G egress: optional timestamp, line 1G PCS words to serializer.
// R15 - Receive words go out with a word-rate strobe.
// R16 - Two 32-bit deserializer words widen into one core word.
// R17 - Lane sync toggles once per core word, locked to received data.
// R18 - Loopback sends received words straight to the transmit side.
// R19 - Three FIR coefficients decode independently to thermometer codes.
// R20 - Signal monitoring is active only in 10G modes.
// R21 - Unity-gain monitoring disables adaptation and zeroes DFE taps.
// R22 - WAN enable is one setting for receive and transmit together.
// R23 - Mode, host width and 1G lane settings steer every multiplexer.
`default_nettype none
module pdr_mode_router #(
    parameter int WORD_W = pdr_pkg::WORD_W,
    parameter int CORE_W = pdr_pkg::CORE_W
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WORD_W-1:0] lineRxWord,
    input wire logic lineRxValid,
    output logic [CORE_W-1:0] coreRxData,
    output logic wanRxValid,
    output logic pcs10RxValid,
    output logic pcs1RxValid,
    output logic rxWordStrobe,
    output logic laneSync,
    input wire logic [CORE_W-1:0] ing10gData,
    input wire logic ing10gValid,
    input wire logic [CORE_W-1:0] ing1gData,
    input wire logic ing1gValid,
    input wire logic [CORE_W-1:0] ingTsData,
    input wire logic ingTsValid,
    output logic ingTsEnable,
    output logic [CORE_W-1:0] hostTxData,
    output logic hostTxValid,
    output logic xgxsEnable,
    output logic hostPcs1gEnable,
    output logic [3:0] hostTxLaneEn,
    output logic [3:0] hostRxLaneEn,
    output logic egrTsEnable,
    input wire logic [WORD_W-1:0] wanTxWord,
    input wire logic wanTxValid,
    input wire logic [WORD_W-1:0] pcs10TxWord,
    input wire logic pcs10TxValid,
    input wire logic [WORD_W-1:0] pcs1TxWord,
    input wire logic pcs1TxValid,
    output logic [WORD_W-1:0] lineTxWord,
    output logic lineTxValid,
    output logic wanRxEnable,
    output logic wanTxEnable,
    output logic [6:0] preTherm,
    output logic [14:0] mainTherm,
    output logic [6:0] postTherm,
    output logic monActive,
    output logic adaptEnable,
    output logic dfeZero
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CORE_W != 2 * WORD_W || WORD_W != pdr_pkg::WORD_W) begin : g_bad_w
        $error("pdr_mode_router: core word must be two 32-bit words");
    end

    pdr_pkg::pdr_state_t s_r;
    pdr_pkg::pdr_state_t s_nxt;
    logic [31:0] ctrlView;
    logic [31:0] firView;
    logic [31:0] statView;
    logic [31:0] thermView;
    logic is10g;

    assign is10g = (s_r.mode != pdr_pkg::MODE_1G);

    // ------------------------------------------------------------
    // Thermometer decode, one loop over the widest field
    // ------------------------------------------------------------
    for (genvar i = 0; i < 15; i++) begin : g_therm
        assign mainTherm[i] = (5'(s_r.firMain) > 5'(i)); // R19
        if (i < 7) begin : g_short
            assign preTherm[i] = (4'(s_r.firPre) > 4'(i)); // R19
            assign postTherm[i] = (4'(s_r.firPost) > 4'(i)); // R19
        end
    end

    // ------------------------------------------------------------
    // Register views
    // ------------------------------------------------------------
    always_comb begin
        ctrlView = '0;
        ctrlView[pdr_pkg::CTRL_MODE_LSB +: 2] = s_r.mode;
        ctrlView[pdr_pkg::CTRL_RXAUI] = s_r.rxaui;
        ctrlView[pdr_pkg::CTRL_LANE3] = s_r.lane3;
        ctrlView[pdr_pkg::CTRL_ING_TS] = s_r.ingTs;
        ctrlView[pdr_pkg::CTRL_EGR_TS] = s_r.egrTs;
        ctrlView[pdr_pkg::CTRL_LOOP] = s_r.loopback;
        ctrlView[pdr_pkg::CTRL_MON] = s_r.monReq;
        ctrlView[pdr_pkg::CTRL_UNITY] = s_r.unity;
        firView = '0;
        firView[pdr_pkg::FIR_PRE_LSB +: pdr_pkg::PRE_W] = s_r.firPre;
        firView[pdr_pkg::FIR_MAIN_LSB +: pdr_pkg::MAIN_W] = s_r.firMain;
        firView[pdr_pkg::FIR_POST_LSB +: pdr_pkg::POST_W] = s_r.firPost;
        statView = '0;
        statView[pdr_pkg::STAT_WAN] = wanRxEnable;
        statView[pdr_pkg::STAT_MON] = monActive;
        statView[pdr_pkg::STAT_SYNC] = s_r.laneSync;
        statView[pdr_pkg::STAT_HALF] = (s_r.dmx == pdr_pkg::DMX_HIGH);
        thermView = '0;
        thermView[6:0] = preTherm;
        thermView[pdr_pkg::THERM_MAIN_LSB +: 15] = mainTherm;
        thermView[pdr_pkg::THERM_POST_LSB +: 7] = postTherm;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ce) begin
            // Read data is captured once, then held to the access edge
            if (psel && !s_r.rdy) begin
                s_nxt.rdy = 1'b1;
                s_nxt.pslverr = 1'b0;
                s_nxt.prdata = '0;
                if (paddr == pdr_pkg::OFF_CTRL) begin
                    s_nxt.prdata = pwrite ? '0 : ctrlView;
                end else if (paddr == pdr_pkg::OFF_FIR) begin
                    s_nxt.prdata = pwrite ? '0 : firView;
                end else if (paddr == pdr_pkg::OFF_STATUS) begin
                    s_nxt.prdata = pwrite ? '0 : statView;
                end else if (paddr == pdr_pkg::OFF_THERM) begin
                    s_nxt.prdata = pwrite ? '0 : thermView;
                end else begin
                    s_nxt.pslverr = 1'b1;
                end
            end
            if (psel && penable && s_r.rdy) begin
                s_nxt.rdy = 1'b0;
                if (pwrite && paddr == pdr_pkg::OFF_CTRL) begin
                    // Reserved mode code leaves the mode unchanged
                    if (pwdata[pdr_pkg::CTRL_MODE_LSB +: 2]
                            != pdr_pkg::MODE_BAD) begin
                        s_nxt.mode = pdr_pkg::pdr_mode_t'(
                            pwdata[pdr_pkg::CTRL_MODE_LSB +: 2]); // R23
                    end
                    s_nxt.rxaui = pwdata[pdr_pkg::CTRL_RXAUI];
                    s_nxt.lane3 = pwdata[pdr_pkg::CTRL_LANE3];
                    s_nxt.ingTs = pwdata[pdr_pkg::CTRL_ING_TS];
                    s_nxt.egrTs = pwdata[pdr_pkg::CTRL_EGR_TS];
                    s_nxt.loopback = pwdata[pdr_pkg::CTRL_LOOP];
                    s_nxt.monReq = pwdata[pdr_pkg::CTRL_MON];
                    s_nxt.unity = pwdata[pdr_pkg::CTRL_UNITY];
                end else if (pwrite && paddr == pdr_pkg::OFF_FIR) begin
                    s_nxt.firPre =
                        pwdata[pdr_pkg::FIR_PRE_LSB +: pdr_pkg::PRE_W];
                    s_nxt.firMain =
                        pwdata[pdr_pkg::FIR_MAIN_LSB +: pdr_pkg::MAIN_W];
                    s_nxt.firPost =
                        pwdata[pdr_pkg::FIR_POST_LSB +: pdr_pkg::POST_W];
                end
            end
            // Receive demux: low word first, then high word
            s_nxt.wanRxValid = 1'b0;
            s_nxt.pcs10RxValid = 1'b0;
            s_nxt.pcs1RxValid = 1'b0;
            if (lineRxValid) begin
                case (s_r.dmx)
                    pdr_pkg::DMX_LOW: begin
                        s_nxt.lowWord = lineRxWord;
                        s_nxt.dmx = pdr_pkg::DMX_HIGH;
                    end
                    default: begin
                        s_nxt.coreRxData = {lineRxWord, s_r.lowWord}; // R16
                        s_nxt.dmx = pdr_pkg::DMX_LOW;
                        s_nxt.laneSync = ~s_r.laneSync; // R17
                        case (s_r.mode)
                            pdr_pkg::MODE_WAN: s_nxt.wanRxValid = 1'b1; // R02
                            pdr_pkg::MODE_1G: s_nxt.pcs1RxValid = 1'b1; // R03
                            default: s_nxt.pcs10RxValid = 1'b1; // R03
                        endcase
                    end
                endcase
            end
            // A half word from the old mode must not leak into the new one
            if (s_nxt.mode != s_r.mode) begin
                s_nxt.dmx = pdr_pkg::DMX_LOW;
            end
            // Ingress toward the host
            s_nxt.hostTxValid = 1'b0;
            if (s_r.mode == pdr_pkg::MODE_1G) begin
                if (s_r.ingTs) begin
                    s_nxt.hostTxValid = ingTsValid; // R04
                    if (ingTsValid) begin
                        s_nxt.hostTxData = ingTsData;
                    end
                end else begin
                    s_nxt.hostTxValid = ing1gValid; // R08
                    if (ing1gValid) begin
                        s_nxt.hostTxData = ing1gData;
                    end
                end
            end else begin
                s_nxt.hostTxValid = ing10gValid; // R05
                if (ing10gValid) begin
                    s_nxt.hostTxData = ing10gData;
                end
            end
            // Egress toward the line serializer
            s_nxt.lineTxValid = 1'b0;
            if (s_r.loopback) begin
                s_nxt.lineTxValid = lineRxValid; // R18
                if (lineRxValid) begin
                    s_nxt.lineTxWord = lineRxWord;
                end
            end else begin
                case (s_r.mode)
                    pdr_pkg::MODE_WAN: begin
                        s_nxt.lineTxValid = wanTxValid; // R13
                        if (wanTxValid) begin
                            s_nxt.lineTxWord = wanTxWord;
                        end
                    end
                    pdr_pkg::MODE_1G: begin
                        s_nxt.lineTxValid = pcs1TxValid; // R14
                        if (pcs1TxValid) begin
                            s_nxt.lineTxWord = pcs1TxWord;
                        end
                    end
                    default: begin
                        s_nxt.lineTxValid = pcs10TxValid; // R12
                        if (pcs10TxValid) begin
                            s_nxt.lineTxWord = pcs10TxWord;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.mode <= pdr_pkg::MODE_LAN;
            s_r.dmx <= pdr_pkg::DMX_LOW;
            s_r.firPre <= pdr_pkg::FIR_PRE_RST;
            s_r.firMain <= pdr_pkg::FIR_MAIN_RST;
            s_r.firPost <= pdr_pkg::FIR_POST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pslverr = s_r.pslverr;
    assign pready = ce & psel & penable & s_r.rdy;
    assign coreRxData = s_r.coreRxData;
    assign wanRxValid = s_r.wanRxValid;
    assign pcs10RxValid = s_r.pcs10RxValid;
    assign pcs1RxValid = s_r.pcs1RxValid;
    assign rxWordStrobe = s_r.wanRxValid | s_r.pcs10RxValid
        | s_r.pcs1RxValid; // R15
    assign laneSync = s_r.laneSync;
    assign hostTxData = s_r.hostTxData;
    assign hostTxValid = s_r.hostTxValid;
    assign lineTxWord = s_r.lineTxWord;
    assign lineTxValid = s_r.lineTxValid;
    assign ingTsEnable = (s_r.mode == pdr_pkg::MODE_1G) & s_r.ingTs; // R04
    assign egrTsEnable = s_r.egrTs; // R11
    assign xgxsEnable = is10g; // R05
    assign hostPcs1gEnable = ~is10g; // R08
    assign wanRxEnable = (s_r.mode == pdr_pkg::MODE_WAN); // R22
    assign wanTxEnable = wanRxEnable; // R22

    // Both directions share one lane mask source
    always_comb begin
        if (!is10g) begin
            hostTxLaneEn = s_r.lane3 ? pdr_pkg::LANE_THREE
                : pdr_pkg::LANE_ZERO; // R10
        end else if (s_r.rxaui) begin
            hostTxLaneEn = pdr_pkg::LANES_RXAUI; // R06
        end else begin
            hostTxLaneEn = pdr_pkg::LANES_XAUI; // R05
        end
        hostRxLaneEn = hostTxLaneEn; // R07 R10 R11
    end

    // Monitor request is ignored in 1G
    assign monActive = s_r.monReq & is10g; // R20
    assign adaptEnable = ~(monActive & s_r.unity); // R21
    assign dfeZero = monActive & s_r.unity; // R21

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_wan_both_ways: assert property ( // R22
        wanRxEnable == wanTxEnable
        && wanRxEnable == (s_r.mode == pdr_pkg::MODE_WAN))
        else $error("WAN enable differs between directions");

    chk_wan_rx_route: assert property ( // R02
        (ce && lineRxValid && s_r.dmx == pdr_pkg::DMX_HIGH
         && s_r.mode == pdr_pkg::MODE_WAN)
        |=> wanRxValid && !pcs10RxValid && !pcs1RxValid)
        else $error("WAN core word not routed to framer");

    chk_lan_1g_route: assert property ( // R03
        (ce && lineRxValid && s_r.dmx == pdr_pkg::DMX_HIGH
         && s_r.mode != pdr_pkg::MODE_WAN)
        |=> (pcs10RxValid != pcs1RxValid) && !wanRxValid)
        else $error("Core word not routed to one PCS");

    chk_rxaui_lanes: assert property ( // R06
        (is10g && s_r.rxaui) |-> hostTxLaneEn == 4'h5)
        else $error("RXAUI not on lanes 0 and 2");

    chk_1g_lane_pair: assert property ( // R10
        !is10g |-> hostTxLaneEn == hostRxLaneEn
        && (hostTxLaneEn == 4'h1 || hostTxLaneEn == 4'h8))
        else $error("1G lanes not paired");

    chk_demux_pair: assert property ( // R16
        (ce && lineRxValid && s_r.dmx == pdr_pkg::DMX_LOW)
        ##1 (ce && lineRxValid && s_r.dmx == pdr_pkg::DMX_HIGH)
        |=> coreRxData == {$past(lineRxWord), $past(lineRxWord, 2)})
        else $error("Core word halves misordered");

    chk_loop_path: assert property ( // R18
        (ce && s_r.loopback && lineRxValid)
        |=> lineTxValid && lineTxWord == $past(lineRxWord))
        else $error("Loopback word lost");

    chk_sync_strobe: assert property ( // R17
        $changed(laneSync) |-> rxWordStrobe)
        else $error("Lane sync moved without a core word");

    chk_therm_count: assert property ( // R19
        $countones(preTherm) == 32'(s_r.firPre)
        && $countones(mainTherm) == 32'(s_r.firMain)
        && $countones(postTherm) == 32'(s_r.firPost))
        else $error("Thermometer code not linear");

    chk_mon_10g_only: assert property ( // R20
        monActive |-> s_r.mode != pdr_pkg::MODE_1G)
        else $error("Monitor active in 1G");

    chk_unity_taps: assert property ( // R21
        (monActive && s_r.unity) |-> !adaptEnable && dfeZero)
        else $error("Unity gain with adaptation on");

    cov_wan_word: cover property (wanRxValid);
    cov_loopback: cover property (s_r.loopback && lineTxValid);
    cov_1g_lane3: cover property (hostTxValid && hostTxLaneEn == 4'h8);
    cov_rxaui_tx: cover property (hostTxValid && hostTxLaneEn == 4'h5);

endmodule : pdr_mode_router
`default_nettype wire

//--- sim/pdr_host_model.sv
`default_nettype none
module pdr_host_model (
    input wire logic mclk,
    input wire logic fire,
    input wire logic [63:0] seed,
    output logic [95:0] txWords,
    output logic [2:0] txValid,
    output logic [191:0] ingWords,
    output logic [2:0] ingValid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Source words, distinct per source
    // ----------------------------------------
    // Idle buses flip every cycle so stale data never passes for fresh
    always_ff @(posedge mclk) begin
        txValid <= {3{fire}};
        ingValid <= {3{fire}};
        if (fire) begin
            txWords <= {seed[31:0] ^ 32'h3, seed[31:0] ^ 32'h2,
                        seed[31:0] ^ 32'h1};
            ingWords <= {seed ^ 64'h3, seed ^ 64'h2, seed ^ 64'h1};
        end else begin
            txWords <= ~txWords;
            ingWords <= ~ingWords;
        end
    end
endmodule : pdr_host_model
`default_nettype wire

//--- sim/tb_phy_datapath_mode_router.sv
`default_nettype none
module tb_phy_datapath_mode_router;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
    logic lineRxValid, wanRxValid, pcs10RxValid, pcs1RxValid;
    logic rxWordStrobe, laneSync, hostTxValid, xgxsEnable, hostPcs1gEnable;
    logic ingTsEnable, egrTsEnable, lineTxValid, wanRxEnable, wanTxEnable;
    logic monActive, adaptEnable, dfeZero, fire, err, ls;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, lineRxWord, lineTxWord, q, ctrl, fir;
    logic [63:0] coreRxData, hostTxData, seed, w;
    logic [3:0] hostTxLaneEn, hostRxLaneEn;
    logic [6:0] preTherm, postTherm;
    logic [14:0] mainTherm;
    logic [95:0] txWords;
    logic [191:0] ingWords;
    logic [2:0] txValid, ingValid;
    int errTotal = 0, cmpCount = 0, cycles = 0;
    logic g, mon;

    pdr_mode_router uut (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lineRxWord(lineRxWord),
        .lineRxValid(lineRxValid), .coreRxData(coreRxData),
        .wanRxValid(wanRxValid), .pcs10RxValid(pcs10RxValid),
        .pcs1RxValid(pcs1RxValid), .rxWordStrobe(rxWordStrobe),
        .laneSync(laneSync), .ing10gData(ingWords[63:0]),
        .ing10gValid(ingValid[0]), .ing1gData(ingWords[127:64]),
        .ing1gValid(ingValid[1]), .ingTsData(ingWords[191:128]),
        .ingTsValid(ingValid[2]), .ingTsEnable(ingTsEnable),
        .hostTxData(hostTxData), .hostTxValid(hostTxValid),
        .xgxsEnable(xgxsEnable), .hostPcs1gEnable(hostPcs1gEnable),
        .hostTxLaneEn(hostTxLaneEn), .hostRxLaneEn(hostRxLaneEn),
        .egrTsEnable(egrTsEnable), .wanTxWord(txWords[31:0]),
        .wanTxValid(txValid[0]), .pcs10TxWord(txWords[63:32]),
        .pcs10TxValid(txValid[1]), .pcs1TxWord(txWords[95:64]),
        .pcs1TxValid(txValid[2]), .lineTxWord(lineTxWord),
        .lineTxValid(lineTxValid), .wanRxEnable(wanRxEnable),
        .wanTxEnable(wanTxEnable), .preTherm(preTherm),
        .mainTherm(mainTherm), .postTherm(postTherm),
        .monActive(monActive), .adaptEnable(adaptEnable), .dfeZero(dfeZero));

    pdr_host_model partner (.mclk(mclk), .fire(fire), .seed(seed),
        .txWords(txWords), .txValid(txValid), .ingWords(ingWords),
        .ingValid(ingValid));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // Hang guard, far above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [64:0] e,
                       input logic [64:0] s);
        cmpCount++;
        if (s !== e) begin
            errTotal++;
            $display("CHECK FAILED %s exp %h got %h", name, e, s);
        end
    endtask : chk

    task automatic apbXfer(input logic wr, input logic [7:0] a,
                           input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apbXfer

    task automatic rxPair(input logic [63:0] v);
        @(posedge mclk);
        lineRxValid <= 1'b1;
        lineRxWord <= v[31:0];
        @(posedge mclk);
        lineRxWord <= v[63:32];
        @(posedge mclk);
        lineRxValid <= 1'b0;
        lineRxWord <= ~v[63:32];
        #1;
    endtask : rxPair

    function automatic logic [3:0] laneExp(input logic [31:0] c);
        if (c[1:0] == 2'h2)
            return c[3] ? pdr_pkg::LANE_THREE : pdr_pkg::LANE_ZERO;
        return c[2] ? pdr_pkg::LANES_RXAUI : pdr_pkg::LANES_XAUI;
    endfunction : laneExp

    function automatic logic [14:0] therm(input logic [3:0] n);
        return 15'((16'h1 << n) - 16'h1);
    endfunction : therm

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, fire} = '0;
        {lineRxValid, lineRxWord, seed} = '0;
        ce = 1'b1;
        void'($urandom(32'hDCC7));
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk("resetLevels", {4'hF, 1'b1, 1'b1, 15'h7FFF},
            {hostTxLaneEn, xgxsEnable, adaptEnable, mainTherm});
        apbXfer(1'b0, pdr_pkg::OFF_THERM, 32'h0);
        chk("resetTherm", 32'h007FFF00, q);
        apbXfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", {1'b1, 32'h0}, {err, q});
        $display("test reset done");
        for (int i = 0; i < 15; i++) begin
            ctrl = ($urandom & 32'h1FC) | 32'(i % 3);
            fir = $urandom & 32'h7F7;
            apbXfer(1'b1, pdr_pkg::OFF_CTRL, ctrl);
            apbXfer(1'b1, pdr_pkg::OFF_FIR, fir);
            apbXfer(1'b0, pdr_pkg::OFF_CTRL, 32'h0);
            chk("ctrl", ctrl, q);
            apbXfer(1'b0, pdr_pkg::OFF_THERM, 32'h0);
            chk("therm", {1'b0, 7'(therm(4'(fir[10:8]))), 1'b0,
                therm(fir[7:4]), 1'b0, 7'(therm(4'(fir[2:0])))}, q);
            g = (ctrl[1:0] == 2'h2);
            mon = ctrl[7] & ~g;
            chk("levels", {laneExp(ctrl), laneExp(ctrl), ~g, g,
                ctrl[1:0] == 2'h1, ctrl[1:0] == 2'h1, mon,
                ~(mon & ctrl[8]), mon & ctrl[8], g & ctrl[4], ctrl[5]},
                {hostTxLaneEn, hostRxLaneEn, xgxsEnable, hostPcs1gEnable,
                wanRxEnable, wanTxEnable, monActive, adaptEnable, dfeZero,
                ingTsEnable, egrTsEnable});
            ls = laneSync;
            w = {$urandom, $urandom};
            rxPair(w);
            chk("rxRoute", {ctrl[1:0] == 2'h1, ctrl[1:0] == 2'h0, g, 1'b1,
                ~ls}, {wanRxValid, pcs10RxValid, pcs1RxValid, rxWordStrobe,
                laneSync});
            chk("coreWord", w, coreRxData);
            chk("loopRx", {ctrl[6], ctrl[6] ? w[63:32] : 32'h0},
                {lineTxValid, ctrl[6] ? lineTxWord : 32'h0});
            seed = {$urandom, $urandom};
            @(posedge mclk);
            fire <= 1'b1;
            @(posedge mclk);
            fire <= 1'b0;
            @(posedge mclk);
            #1;
            chk("hostTx", {1'b1, g ? (ctrl[4] ? seed ^ 64'h3 : seed ^ 64'h2)
                : seed ^ 64'h1}, {hostTxValid, hostTxData});
            chk("lineTx", ctrl[6] ? {1'b0, w[63:32]} : {1'b1, seed[31:0] ^
                (g ? 32'h3 : (ctrl[0] ? 32'h1 : 32'h2))},
                {lineTxValid, lineTxWord});
            $display("test mode pass %0d done", i);
        end
        apbXfer(1'b1, pdr_pkg::OFF_CTRL, 32'h043);
        apbXfer(1'b0, pdr_pkg::OFF_CTRL, 32'h0);
        chk("badMode", {ctrl[1:0], 1'b1}, {q[1:0], q[6]});
        apbXfer(1'b0, pdr_pkg::OFF_STATUS, 32'h0);
        chk("status", {1'b0, ~ls, 1'b0, ctrl[1:0] == 2'h1}, q[3:0]);
        // Clock enable low must freeze the receive demux
        ce <= 1'b0;
        rxPair(w);
        chk("ceFreeze", {1'b0, ~ls}, {rxWordStrobe, laneSync});
        ce <= 1'b1;
        $display("test reserved mode done");
        final_report();
    end
endmodule : tb_phy_datapath_mode_router
`default_nettype wire
